//--- sbc_diag_and_mode_registers.sv
// diagnostic and mode register bank behind a 16-bit serial port
// assumes serial clock well below core_clk/4; all pins are asynchronous
`timescale 1ns/1ns
module sbc_diag_and_mode_registers #(
  parameter logic KEEPALIVE_DEFAULT = 1'b1,
  parameter int   TIMED_WAKE_CNT    = sbc_diag_pkg::TIMED_WAKE_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    sclk,
  input  wire logic                    chip_select_n,
  input  wire logic                    mosi,
  output logic                         miso,
  output logic                         miso_oe_n,
  input  wire sbc_diag_pkg::can_fault_t can_fault,
  input  wire sbc_diag_pkg::group_in_t group_in,
  input  wire logic                    init_state,
  input  wire logic                    normal_state,
  input  wire logic                    wake_event,
  input  wire logic                    deep_failsafe_exit,
  output logic                         keepalive_supply_enable,
  output logic                         low_power_off,
  output logic                         int_pulse
);
  import sbc_diag_pkg::*;

  localparam int NPIN = 17;
  localparam int TW   = $clog2(TIMED_WAKE_CNT + 1);
  // chip select idles high: resetting its stages low would fake a
  // frame end on release and raise a clock count error
  localparam logic [NPIN-1:0] SYNC_RST = {2'b01, {(NPIN - 2){1'b0}}};

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  wire  [NPIN-1:0] pin_vec = {sclk, chip_select_n, mosi, can_fault,
                              group_in, init_state, normal_state,
                              wake_event, deep_failsafe_exit};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
    end else begin
      s1_q <= pin_vec;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  wire             sclk_s   = s2_q[16];
  wire             cs_n_s   = s2_q[15];
  wire             mosi_s   = s2_q[14];
  wire can_fault_t fault_s  = can_fault_t'(s2_q[13:9]);
  wire group_in_t  group_s  = group_in_t'(s2_q[8:4]);
  wire             init_s   = s2_q[3];
  wire             normal_s = s2_q[2];
  wire             wake_s   = s2_q[1];
  wire             sclk_rise = sclk_s & ~s3_q[16];
  wire             sclk_fall = ~sclk_s & s3_q[16];
  wire             cs_fall   = ~cs_n_s & s3_q[15];
  wire             cs_rise   = cs_n_s & ~s3_q[15];
  wire             dfs_rise  = s2_q[0] & ~s3_q[0];
  wire             in_frame  = ~cs_n_s;

  // ---------------------------------------------------------------
  // flag storage
  // ---------------------------------------------------------------
  logic [4:0] can_q;
  logic [4:0] can_d;
  logic [3:0] ser_q;
  logic [3:0] ser_d;
  logic [1:0] res_q;
  logic [1:0] res_d;
  logic       keep_q;
  logic       keep_d;

  function automatic logic [7:0] read_byte(input logic [5:0] a,
                                           input logic [4:0] c,
                                           input logic [3:0] s,
                                           input logic [1:0] r,
                                           input logic       k,
                                           input logic       ini,
                                           input logic       nrm);
    logic [7:0] b;
    b = BYTE_RST;
    case (a)
      ADDR_CAN_A: begin
        b[BUS_DOM_BIT] = c[4];
        b[RX_REC_BIT]  = c[3];
        b[TX_DOM_BIT]  = c[2];
      end
      ADDR_CAN_B: begin
        b[OVERTEMP_BIT] = c[1];
        b[OVERCURR_BIT] = c[0];
      end
      ADDR_SER: begin
        b[SER_SEC_BIT] = s[3];
        b[SER_CLK_BIT] = s[2];
        b[SER_REQ_BIT] = s[1];
        b[SER_PAR_BIT] = s[0];
      end
      ADDR_MODE: begin
        b[KEEPALIVE_BIT] = k;
        b[INIT_ST_BIT]   = ini;
        b[NORMAL_ST_BIT] = nrm;
        b[DFS_RES_BIT]   = r[1];
        b[SLP_RES_BIT]   = r[0];
      end
      default: b = BYTE_RST;
    endcase
    return b;
  endfunction : read_byte

  function automatic logic known_addr(input logic [5:0] a);
    return (a == ADDR_CAN_A) || (a == ADDR_CAN_B) ||
           (a == ADDR_SER) || (a == ADDR_MODE);
  endfunction : known_addr

  // ---------------------------------------------------------------
  // frame receive and response
  // ---------------------------------------------------------------
  logic [15:0] rx_q;
  logic [4:0]  fcnt_q;
  logic [3:0]  rcnt_q;
  logic        fall_d1_q;
  logic [7:0]  grp_q;
  logic [7:0]  lo_q;
  logic        miso_q;

  // summary bits: serial, wake, transceiver, reserved, io, prereg,
  // core, misc
  wire [7:0] group_now = {|ser_q, group_s.wake, |can_q, 1'b0,
                          group_s.io, group_s.preregulator,
                          group_s.core_supply, group_s.misc};
  wire [5:0] early_addr = rx_q[5:0];
  wire [15:0] resp_word = {grp_q, lo_q};
  wire [3:0] rcnt_nx    = rcnt_q + 4'h1;
  wire [3:0] tx_idx     = 4'hF - rcnt_nx;
  wire       load_lo    = fall_d1_q && (fcnt_q == 5'(ADDR_FALLS));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_q      <= '0;
      fcnt_q    <= '0;
      rcnt_q    <= '0;
      fall_d1_q <= 1'b0;
      grp_q     <= GROUP_RST;
      lo_q      <= BYTE_RST;
      miso_q    <= 1'b0;
    end else begin
      fall_d1_q <= in_frame && sclk_fall;
      if (cs_fall) begin
        fcnt_q <= '0;
        rcnt_q <= '0;
        grp_q  <= group_now;
        lo_q   <= BYTE_RST;
        miso_q <= group_now[7];
      end else if (in_frame) begin
        if (sclk_fall) begin
          rx_q <= {rx_q[14:0], mosi_s};
          if (fcnt_q != 5'h1F) begin
            fcnt_q <= fcnt_q + 5'h1;
          end
        end
        if (sclk_rise && rcnt_q != 4'hF) begin
          rcnt_q <= rcnt_nx;
          miso_q <= resp_word[tx_idx];
        end
        if (load_lo) begin
          lo_q <= read_byte(early_addr, can_q, ser_q, res_q, keep_q,
                            init_s, normal_s);
        end
      end
    end
  end

  assign miso      = miso_q;
  assign miso_oe_n = cs_n_s;

  // ---------------------------------------------------------------
  // frame check at chip select release
  // ---------------------------------------------------------------
  wire [5:0] f_addr   = rx_q[ADDR_MSB:ADDR_LSB];
  wire       f_write  = rx_q[RW_BIT];
  wire       cnt_ok   = (fcnt_q == 5'(FRAME_BITS));
  // odd parity over the whole word, parity bit included
  wire       par_ok   = ^rx_q;
  wire       sec_ok   = rx_q[3:0] ==
                        {~rx_q[5], ~rx_q[4], rx_q[7], rx_q[6]};
  wire       rd_shape = (rx_q[PARITY_BIT:0] == 9'h000);
  wire       is_mode  = (f_addr == ADDR_MODE);
  wire       end_ok   = cs_rise && cnt_ok;

  wire set_clk = cs_rise && !cnt_ok;
  wire set_par = end_ok && f_write && !par_ok;
  wire set_sec = end_ok && f_write && is_mode && !sec_ok;
  wire set_req = end_ok && (f_write ? !is_mode
                 : (!known_addr(f_addr) || !rd_shape));
  wire write_ok = end_ok && f_write && is_mode && par_ok && sec_ok;
  wire read_ok  = end_ok && !f_write && known_addr(f_addr) && rd_shape;

  // clear only what was actually returned, so a flag rising during
  // the frame survives to the next read
  wire [4:0] can_clr = {read_ok && f_addr == ADDR_CAN_A && lo_q[BUS_DOM_BIT],
                        read_ok && f_addr == ADDR_CAN_A && lo_q[RX_REC_BIT],
                        read_ok && f_addr == ADDR_CAN_A && lo_q[TX_DOM_BIT],
                        read_ok && f_addr == ADDR_CAN_B && lo_q[OVERTEMP_BIT],
                        read_ok && f_addr == ADDR_CAN_B && lo_q[OVERCURR_BIT]};
  wire [3:0] ser_clr = {4{read_ok && f_addr == ADDR_SER}} &
                       {lo_q[SER_SEC_BIT], lo_q[SER_CLK_BIT],
                        lo_q[SER_REQ_BIT], lo_q[SER_PAR_BIT]};
  wire [1:0] res_clr = {2{read_ok && is_mode}} &
                       {lo_q[DFS_RES_BIT], lo_q[SLP_RES_BIT]};

  // ---------------------------------------------------------------
  // low-power control
  // ---------------------------------------------------------------
  lp_state_t     lp_q;
  lp_state_t     lp_d;
  logic [TW-1:0] tmr_q;
  logic [TW-1:0] tmr_d;
  logic          int_q;
  logic          wake_done;

  wire req_timed = write_ok && rx_q[TIMED_SLP_BIT];
  wire req_sleep = write_ok && rx_q[SLEEP_REQ_BIT];

  always_comb begin
    lp_d      = lp_q;
    tmr_d     = tmr_q;
    wake_done = 1'b0;
    case (lp_q)
      LP_ACTIVE: begin
        // timed sleep takes priority when both requests arrive
        if (req_timed) begin
          lp_d  = LP_TIMED;
          tmr_d = TW'(TIMED_WAKE_CNT - 1);
        end else if (req_sleep) begin
          lp_d = LP_SLEEP;
        end
      end
      LP_SLEEP: begin
        if (wake_s) begin
          lp_d      = LP_ACTIVE;
          wake_done = 1'b1;
        end
      end
      LP_TIMED: begin
        if (tmr_q == '0 || wake_s) begin
          lp_d      = LP_ACTIVE;
          wake_done = 1'b1;
        end else begin
          tmr_d = tmr_q - TW'(1);
        end
      end
      default: lp_d = LP_ACTIVE;
    endcase
  end

  // ---------------------------------------------------------------
  // flag next values: a new event wins over a read clear
  // ---------------------------------------------------------------
  assign can_d = (can_q & ~can_clr) |
                 {fault_s.bus_dominant,
                  fault_s.rx_recessive,
                  fault_s.tx_dominant,
                  fault_s.overtemp,
                  fault_s.overcurrent};
  assign ser_d = (ser_q & ~ser_clr) |
                 {set_sec, set_clk, set_req, set_par};
  assign res_d = (res_q & ~res_clr) | {dfs_rise, wake_done};
  assign keep_d = write_ok ? rx_q[KEEPALIVE_BIT] : keep_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      can_q  <= '0;
      ser_q  <= '0;
      res_q  <= '0;
      keep_q <= KEEPALIVE_DEFAULT;
      lp_q   <= LP_ACTIVE;
      tmr_q  <= '0;
      int_q  <= 1'b0;
    end else begin
      can_q  <= can_d;
      ser_q  <= ser_d;
      res_q  <= res_d;
      keep_q <= keep_d;
      lp_q   <= lp_d;
      tmr_q  <= tmr_d;
      int_q  <= write_ok && rx_q[INT_REQ_BIT];
    end
  end

  assign keepalive_supply_enable = keep_q;
  assign low_power_off           = (lp_q != LP_ACTIVE);
  assign int_pulse               = int_q;

endmodule : sbc_diag_and_mode_registers

//--- sbc_diag_checker.sv
// assertions on the register bank ports, bound to every instance
// assumes pins change on the falling core_clk edge
`timescale 1ns/1ns
module sbc_diag_checker #(
  parameter logic KEEPALIVE_DEFAULT = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic wake_event,
  input wire logic keepalive_supply_enable,
  input wire logic low_power_off,
  input wire logic int_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  chk_oe_release: assert property (
    $rose(chip_select_n) |-> ##[1:3] miso_oe_n)
    else $error("miso still driven after frame end");
  // pins pass a synchroniser, so a rise shows two to four edges late
  chk_miso_on_rise: assert property (
    $changed(miso) && !miso_oe_n && !$past(miso_oe_n, 4)
    |-> $past(sclk, 2) || $past(sclk, 3) || $past(sclk, 4))
    else $error("miso moved without a serial clock rise");
  chk_int_single: assert property (
    int_pulse |=> !int_pulse)
    else $error("interrupt pulse longer than one cycle");
  chk_int_after_frame: assert property (
    $rose(int_pulse) |-> $past(chip_select_n) && !$past(chip_select_n, 8))
    else $error("interrupt pulse away from a frame end");
  chk_keepalive_frame: assert property (
    $changed(keepalive_supply_enable)
    |-> $past(chip_select_n) && !$past(chip_select_n, 8))
    else $error("keep-alive enable moved away from a frame end");
  chk_sleep_frame: assert property (
    $rose(low_power_off) |-> $past(chip_select_n) && !$past(chip_select_n, 8))
    else $error("low power entered away from a frame end");
  chk_wake_ends: assert property (
    low_power_off && $rose(wake_event) |-> ##[1:5] !low_power_off)
    else $error("wake event did not end low power");
  chk_reset_vals: assert property (
    $fell(rst) |-> keepalive_supply_enable == KEEPALIVE_DEFAULT
    && !low_power_off && !int_pulse)
    else $error("outputs wrong after reset");
endmodule : sbc_diag_checker
bind sbc_diag_and_mode_registers sbc_diag_checker #(
  .KEEPALIVE_DEFAULT(KEEPALIVE_DEFAULT)) checker_i (
  .core_clk(core_clk), .rst(rst), .sclk(sclk),
  .chip_select_n(chip_select_n), .miso(miso), .miso_oe_n(miso_oe_n),
  .wake_event(wake_event), .low_power_off(low_power_off),
  .keepalive_supply_enable(keepalive_supply_enable), .int_pulse(int_pulse));

//--- sbc_diag_pkg.sv
// constants and types for the diagnostic and mode register bank
// assumes a 16-bit serial frame, MSB first, and a 10 MHz core clock
package sbc_diag_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int  CLK_PERIOD_NS     = 100;
  localparam real TIMED_WAKE_MS     = 1.0;
  localparam int  TIMED_WAKE_CYCLES =
    int'($ceil(TIMED_WAKE_MS * 1.0e6 / CLK_PERIOD_NS));

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int RW_BIT     = 15;
  localparam int ADDR_MSB   = 14;
  localparam int ADDR_LSB   = 9;
  localparam int PARITY_BIT = 8;
  localparam int ADDR_FALLS = 7;

  // register addresses (frame bits 14..9)
  localparam logic [5:0] ADDR_CAN_A = 6'h11;
  localparam logic [5:0] ADDR_CAN_B = 6'h12;
  localparam logic [5:0] ADDR_SER   = 6'h13;
  localparam logic [5:0] ADDR_MODE  = 6'h15;

  // low-byte field positions
  localparam int BUS_DOM_BIT  = 3;
  localparam int RX_REC_BIT   = 1;
  localparam int TX_DOM_BIT   = 0;
  localparam int OVERTEMP_BIT = 1;
  localparam int OVERCURR_BIT = 0;
  localparam int SER_SEC_BIT  = 7;
  localparam int SER_CLK_BIT  = 5;
  localparam int SER_REQ_BIT  = 3;
  localparam int SER_PAR_BIT  = 1;
  localparam int KEEPALIVE_BIT  = 7;
  localparam int TIMED_SLP_BIT  = 6;
  localparam int SLEEP_REQ_BIT  = 5;
  localparam int INT_REQ_BIT    = 4;
  localparam int INIT_ST_BIT    = 3;
  localparam int NORMAL_ST_BIT  = 2;
  localparam int DFS_RES_BIT    = 1;
  localparam int SLP_RES_BIT    = 0;

  // reset values
  localparam logic [7:0] GROUP_RST = 8'h00;
  localparam logic [7:0] BYTE_RST  = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic bus_dominant;
    logic rx_recessive;
    logic tx_dominant;
    logic overtemp;
    logic overcurrent;
  } can_fault_t;

  typedef struct packed {
    logic wake;
    logic io;
    logic preregulator;
    logic core_supply;
    logic misc;
  } group_in_t;

  typedef enum logic [1:0] {
    LP_ACTIVE = 2'b00,
    LP_SLEEP  = 2'b01,
    LP_TIMED  = 2'b10
  } lp_state_t;

endpackage : sbc_diag_pkg

//--- spi_host.sv
// serial host model: sends frames of any clock count, MSB first
// assumes the caller runs on core_clk; pins move on its falling edge
`timescale 1ns/1ns
module spi_host (
  input  wire logic core_clk,
  input  wire logic miso,
  input  wire logic miso_oe_n,
  output logic      sclk,
  output logic      chip_select_n,
  output logic      mosi
);
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wt
  // extra clocks repeat bit 0; a released miso reads as unknown
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
    rx = 16'h0000;
    chip_select_n = 1'b0;
    wt(5);
    for (int i = 0; i < n; i++) begin
      mosi = tx[(i < 16) ? 15 - i : 0];
      wt(5);
      if (i < 16) rx[15 - i] = (miso_oe_n === 1'b0) ? miso : 1'bx;
      sclk = 1'b1;
      wt(5);
      sclk = 1'b0;
      wt(5);
    end
    chip_select_n = 1'b1;
    mosi = ~mosi;
    wt(10);
  endtask : frame
endmodule : spi_host

//--- testbench.sv
// self-checking bench for the diagnostic and mode register bank
// assumes spi_host.sv as the serial host and the bound checker
`timescale 1ns/1ns
module testbench;
  import sbc_diag_pkg::*;
  localparam int TW = 20;
  logic        core_clk = 1'b0;
  logic        rst, sclk, chip_select_n, mosi, miso, miso_oe_n;
  logic        init_state, normal_state, wake_event, deep_failsafe_exit;
  logic        keepalive_supply_enable, low_power_off, int_pulse;
  can_fault_t  can_fault;
  group_in_t   group_in;
  logic [31:0] seed = 32'hB45D;
  logic [31:0] r;
  logic [15:0] rx;
  logic [15:0] bad [6];
  logic [5:0]  addrs [6] = '{6'h11, 6'h12, 6'h13, 6'h15, 6'h14, 6'h3F};
  logic [3:0]  wn [4] = '{4'h0, 4'h1, 4'h9, 4'h8};
  int          miscompares = 0;
  int          samples_checked = 0;
  int          ka = 1, ca = 0, cb = 0, ser = 0, deep_failsafe_resume_flag = 0, slp = 0;
  int          lp = 0, ep = 0, pulses = 0;

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (int_pulse === 1'b1) pulses++;

  sbc_diag_and_mode_registers #(.TIMED_WAKE_CNT(TW))
    sbc_diag_and_mode_registers_i (
    .core_clk(core_clk), .rst(rst), .sclk(sclk), .mosi(mosi),
    .chip_select_n(chip_select_n), .miso(miso), .miso_oe_n(miso_oe_n),
    .can_fault(can_fault), .group_in(group_in), .init_state(init_state),
    .normal_state(normal_state), .wake_event(wake_event),
    .deep_failsafe_exit(deep_failsafe_exit), .int_pulse(int_pulse),
    .keepalive_supply_enable(keepalive_supply_enable),
    .low_power_off(low_power_off));
  spi_host spi_host_i (
    .core_clk(core_clk), .miso(miso), .miso_oe_n(miso_oe_n), .sclk(sclk),
    .chip_select_n(chip_select_n), .mosi(mosi));

  // ---------------------------------------------------------------
  // reference model and helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [15:0] wr(input logic [3:0] n, input logic [5:0] a);
    logic [15:0] f;
    f = {1'b1, a, 1'b0, n, ~n[1], ~n[0], n[3], n[2]};
    f[8] = ~^f;
    return f;
  endfunction : wr
  // fault levels still high win over a read clear
  task automatic latch();
    ca |= {can_fault.bus_dominant, 1'b0, can_fault.rx_recessive,
           can_fault.tx_dominant};
    cb |= {can_fault.overtemp, can_fault.overcurrent};
  endtask : latch
  task automatic xfer(input logic [15:0] tx, input int n = 16);
    logic [7:0] g;
    logic [7:0] lo;
    int a;
    a = tx[14:9];
    latch();
    g = {|ser, group_in.wake, |(ca | cb), 1'b0, group_in[3:0]};
    case (a)
      17: lo = ca[7:0];
      18: lo = cb[7:0];
      19: lo = ser[7:0];
      21: lo = {ka[0], 3'b000, init_state, normal_state, deep_failsafe_resume_flag[0], slp[0]};
      default: lo = 8'h00;
    endcase
    spi_host_i.frame(tx, n, rx);
    if (n >= 16) check(rx, {g, lo}, "response");
    if (n != 16) ser |= 8'h20;
    else if (tx[15]) begin
      if (^tx !== 1'b1) ser |= 8'h02;
      else if (tx[3:0] != {~tx[5], ~tx[4], tx[7], tx[6]}) ser |= 8'h80;
      else if (a != 21) ser |= 8'h08;
      else begin
        ka = tx[7];
        ep += tx[4];
        lp = tx[6] | tx[5];
      end
    end else if (tx[8:0] != 9'h000 || !(a inside {17, 18, 19, 21}))
      ser |= 8'h08;
    else begin
      case (a)
        17: ca = 0;
        18: cb = 0;
        19: ser = 0;
        default: {deep_failsafe_resume_flag, slp} = 0;
      endcase
      latch();
    end
    check(16'(keepalive_supply_enable), 16'(ka), "keep-alive");
    check(16'(low_power_off), 16'(lp), "low power");
    check(16'(pulses), 16'(ep), "int pulses");
  endtask : xfer
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    {wake_event, deep_failsafe_exit, init_state, normal_state} = 4'b0010;
    can_fault = '0;
    group_in = '0;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    repeat (5) @(negedge core_clk);
    for (int i = 0; i < 18; i++) begin
      r = rnd();
      can_fault = r[4:0] & r[9:5] & r[14:10];
      group_in = r[19:15];
      {init_state, normal_state} = r[21:20];
      repeat (10) @(negedge core_clk);
      xfer({1'b0, addrs[i % 6], 9'h000});
    end
    can_fault = '0;
    $display("register reads done");
    foreach (wn[i]) xfer(wr(wn[i], 6'h15));
    bad = '{wr(4'h1, 6'h15) ^ 16'h0100, wr(4'h1, 6'h15) ^ 16'h0003,
            wr(4'h1, 6'h11), 16'h2A01, 16'h2600, 16'h2600};
    for (int i = 0; i < 6; i++) begin
      xfer(bad[i], i == 4 ? 15 : i == 5 ? 17 : 16);
      xfer(16'h2600);
    end
    $display("frame errors done");
    xfer(wr(4'hA, 6'h15));
    repeat (3 * TW) @(negedge core_clk);
    check(16'(low_power_off), 16'h0001, "sleep held");
    wake_event = 1'b1;
    repeat (8) @(negedge core_clk);
    wake_event = 1'b0;
    lp = 0;
    slp = 1;
    xfer(16'h2A00);
    xfer(wr(4'hC, 6'h15));
    for (int k = 0; k < TW + 20 && low_power_off !== 1'b0; k++)
      @(negedge core_clk);
    check(16'(low_power_off), 16'h0000, "timed wake");
    lp = 0;
    slp = 1;
    deep_failsafe_exit = 1'b1;
    repeat (8) @(negedge core_clk);
    deep_failsafe_exit = 1'b0;
    deep_failsafe_resume_flag = 1;
    xfer(16'h2A00);
    xfer(16'h2A00);
    $display("low power done");
    xfer(wr(4'h0, 6'h15));
    rst = 1'b1;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    {ka, ca, cb, ser} = {32'd1, 96'd0};
    repeat (5) @(negedge core_clk);
    xfer(16'h2A00);
    $display("second reset done");
    test_done();
  end
endmodule : testbench
